// file: aif_status_flags.sv
// low interrupt status flags of the measurement front end, with apb slave
`timescale 1ns/1ps

module aif_status_flags #(
  parameter int ADC_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [aif_pkg::AIF_ADDR_W-1:0] paddr,
  input wire logic [aif_pkg::AIF_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [aif_pkg::AIF_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic adc_valid,
  input wire logic [ADC_W-1:0] adc_result,
  input wire logic temp_ready,
  input wire logic decim_ready,
  input wire logic fourier_ready,
  input wire logic mean_ready,
  input wire logic variance_ready,
  input wire logic seq_wr,
  input wire logic [3:0] seq_wdata
);
  import aif_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (ADC_W < 2 || ADC_W > AIF_LIM_W) begin : g_bad_width
    $error("adc width must be 2 to 16");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] wd,
                                         input logic [3:0] strb);
    logic [15:0] r;
    r = old_v;
    if (strb[0]) begin
      r[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  function automatic logic [12:0] merge13(input logic [12:0] old_v, input logic [31:0] wd,
                                         input logic [3:0] strb);
    logic [12:0] r;
    r = old_v;
    if (strb[0]) begin
      r[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      r[12:8] = wd[12:8];
    end
    return r;
  endfunction

  function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] r;
    r = (a > b) ? (a - b) : (b - a);
    return r;
  endfunction

  function automatic logic mapped(input logic [AIF_ADDR_W-1:0] a);
    logic r;
    r = (a == AIF_OFS_STATUS) || (a == AIF_OFS_MASK) || (a == AIF_OFS_CLEAR) ||
        (a == AIF_OFS_STEP) || (a == AIF_OFS_UPPER) || (a == AIF_OFS_LOWER);
    return r;
  endfunction

  // ----------------------------------------------------------------
  // state and decode
  // ----------------------------------------------------------------
  aif_state_type st_r;
  aif_state_type st_nxt;

  logic [15:0] result_ext;
  logic setup_ph;
  logic wr_acc;
  logic delta_fail;
  logic upper_fail;
  logic lower_fail;
  logic [12:0] set_vec;
  logic [12:0] clr_vec;

  assign result_ext = 16'(adc_result);
  // zero wait states: every access phase completes in its first cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite && mapped(paddr);
  assign prdata = st_r.prdata;
  assign irq = st_r.irq;

  // step compare
  // first result after reset has no predecessor, so no step is judged on it
  assign delta_fail = adc_valid && st_r.prev_valid &&
                      (abs_diff(result_ext, st_r.prev) > st_r.step_thr);
  assign upper_fail = adc_valid && (result_ext > st_r.upper);
  assign lower_fail = adc_valid && (result_ext < st_r.lower);

  always_comb begin
    set_vec = 13'h0000;
    set_vec[AIF_BIT_CONV] = adc_valid;
    set_vec[AIF_BIT_FOURIER] = fourier_ready;
    set_vec[AIF_BIT_DECIM] = decim_ready;
    set_vec[AIF_BIT_TEMP] = temp_ready;
    set_vec[AIF_BIT_LOWER] = lower_fail;
    set_vec[AIF_BIT_UPPER] = upper_fail;
    set_vec[AIF_BIT_STEP] = delta_fail;
    set_vec[AIF_BIT_MEAN] = mean_ready;
    set_vec[AIF_BIT_VAR] = variance_ready;
    // sequencer only
    // the bus can only clear these bits through the clear register, so host writes cannot raise them
    for (int i = 0; i < AIF_NUM_CUST; i++) begin
      set_vec[AIF_BIT_CUST0 + i] = seq_wr && seq_wdata[i];
    end
  end

  always_comb begin
    clr_vec = 13'h0000;
    if (wr_acc && paddr == AIF_OFS_CLEAR) begin
      clr_vec = merge13(13'h0000, pwdata, pstrb);
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.status = (st_r.status & ~clr_vec) | set_vec;
    if (adc_valid) begin
      st_nxt.prev = result_ext;
      st_nxt.prev_valid = 1'b1;
    end
    if (wr_acc) begin
      case (paddr)
        AIF_OFS_MASK: begin
          st_nxt.mask = merge13(st_r.mask, pwdata, pstrb);
        end
        AIF_OFS_STEP: begin
          st_nxt.step_thr = merge16(st_r.step_thr, pwdata, pstrb);
        end
        AIF_OFS_UPPER: begin
          st_nxt.upper = merge16(st_r.upper, pwdata, pstrb);
        end
        AIF_OFS_LOWER: begin
          st_nxt.lower = merge16(st_r.lower, pwdata, pstrb);
        end
        default: begin
          st_nxt.mask = st_r.mask;
        end
      endcase
    end
    // read data captured in setup so it is a flop during access
    if (setup_ph) begin
      case (paddr)
        AIF_OFS_STATUS: st_nxt.prdata = {19'h00000, st_r.status};
        AIF_OFS_MASK: st_nxt.prdata = {19'h00000, st_r.mask};
        AIF_OFS_STEP: st_nxt.prdata = {16'h0000, st_r.step_thr};
        AIF_OFS_UPPER: st_nxt.prdata = {16'h0000, st_r.upper};
        AIF_OFS_LOWER: st_nxt.prdata = {16'h0000, st_r.lower};
        default: st_nxt.prdata = 32'h00000000;
      endcase
    end
    st_nxt.irq = |(st_nxt.status & st_nxt.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.status <= AIF_RST_STATUS;
      st_r.mask <= AIF_RST_MASK;
      st_r.step_thr <= AIF_RST_STEP;
      st_r.upper <= AIF_RST_UPPER;
      st_r.lower <= AIF_RST_LOWER;
      st_r.prev <= 16'h0000;
      st_r.prev_valid <= 1'b0;
      st_r.prdata <= 32'h00000000;
      st_r.irq <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_status_setup;
    psel && !penable && paddr == AIF_OFS_STATUS;
  endsequence

  sequence s_seq_cust3;
    seq_wr && seq_wdata[3];
  endsequence

  property p_custom_read;
    s_status_setup |=> prdata[12:9] == $past(st_r.status[12:9]) && prdata[31:13] == 19'h00000;
  endproperty
  a_custom_read: assert property (p_custom_read) else $error("custom flags misread");

  property p_step_set;
    adc_valid && st_r.prev_valid && (abs_diff(result_ext, st_r.prev) > st_r.step_thr)
      |=> st_r.status[AIF_BIT_STEP];
  endproperty
  a_step_set: assert property (p_step_set) else $error("step flag not set");

  property p_step_sticky;
    st_r.status[AIF_BIT_STEP] && !clr_vec[AIF_BIT_STEP] |=> st_r.status[AIF_BIT_STEP];
  endproperty
  a_step_sticky: assert property (p_step_sticky) else $error("step flag dropped");

  property p_upper_cause;
    $rose(st_r.status[AIF_BIT_UPPER]) |->
      $past(adc_valid) && ($past(result_ext) > $past(st_r.upper));
  endproperty
  a_upper_cause: assert property (p_upper_cause) else $error("upper flag without cause");

  property p_lower_set;
    adc_valid && result_ext < st_r.lower |=> st_r.status[AIF_BIT_LOWER];
  endproperty
  a_lower_set: assert property (p_lower_set) else $error("lower flag not set");

  property p_lower_sticky;
    st_r.status[AIF_BIT_LOWER] && !clr_vec[AIF_BIT_LOWER] |=> st_r.status[AIF_BIT_LOWER];
  endproperty
  a_lower_sticky: assert property (p_lower_sticky) else $error("lower flag dropped");

  property p_temp_set;
    temp_ready |=> st_r.status[AIF_BIT_TEMP];
  endproperty
  a_temp_set: assert property (p_temp_set) else $error("temperature flag not set");

  property p_decim_set;
    decim_ready |=> st_r.status[AIF_BIT_DECIM];
  endproperty
  a_decim_set: assert property (p_decim_set) else $error("filter flag not set");

  property p_fourier_set;
    fourier_ready |=> st_r.status[AIF_BIT_FOURIER];
  endproperty
  a_fourier_set: assert property (p_fourier_set) else $error("fourier flag not set");

  property p_conv_set;
    adc_valid |=> st_r.status[AIF_BIT_CONV];
  endproperty
  a_conv_set: assert property (p_conv_set) else $error("conversion flag not set");

  property p_stats_set;
    variance_ready && mean_ready |=> st_r.status[AIF_BIT_VAR] && st_r.status[AIF_BIT_MEAN];
  endproperty
  a_stats_set: assert property (p_stats_set) else $error("statistics flags not set");

  property p_cust_only_seq;
    s_seq_cust3 |=> st_r.status[AIF_BIT_CUST0 + 3] ##0 irq == |(st_r.status & st_r.mask);
  endproperty
  a_cust_only_seq: assert property (p_cust_only_seq) else $error("custom flag not set");

  // no custom bit may go from 0 to 1 unless the sequencer strobe was seen
  property p_cust_no_bus_set;
    !seq_wr |=> (st_r.status[12:9] & ~$past(st_r.status[12:9])) == 4'h0;
  endproperty
  a_cust_no_bus_set: assert property (p_cust_no_bus_set)
    else $error("custom flag set without sequencer");

endmodule

// file: aif_pkg.sv
// constants and state type for the low interrupt status flags block
package aif_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int AIF_ADDR_W = 8;
  localparam int AIF_DATA_W = 32;
  localparam int AIF_FLAG_W = 13;
  localparam int AIF_LIM_W = 16;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] AIF_OFS_STATUS = 8'h00;
  localparam logic [7:0] AIF_OFS_MASK = 8'h04;
  localparam logic [7:0] AIF_OFS_CLEAR = 8'h08;
  localparam logic [7:0] AIF_OFS_STEP = 8'h0c;
  localparam logic [7:0] AIF_OFS_UPPER = 8'h10;
  localparam logic [7:0] AIF_OFS_LOWER = 8'h14;

  // ----------------------------------------------------------------
  // flag positions in the status word
  // ----------------------------------------------------------------
  localparam int AIF_BIT_CONV = 0;
  localparam int AIF_BIT_FOURIER = 1;
  localparam int AIF_BIT_DECIM = 2;
  localparam int AIF_BIT_TEMP = 3;
  localparam int AIF_BIT_LOWER = 4;
  localparam int AIF_BIT_UPPER = 5;
  localparam int AIF_BIT_STEP = 6;
  localparam int AIF_BIT_MEAN = 7;
  localparam int AIF_BIT_VAR = 8;
  localparam int AIF_BIT_CUST0 = 9;
  localparam int AIF_NUM_CUST = 4;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [12:0] AIF_RST_STATUS = 13'h0000;
  localparam logic [12:0] AIF_RST_MASK = 13'h0000;
  localparam logic [15:0] AIF_RST_STEP = 16'hffff;
  localparam logic [15:0] AIF_RST_UPPER = 16'hffff;
  localparam logic [15:0] AIF_RST_LOWER = 16'h0000;

  typedef struct packed {
    logic [12:0] status;
    logic [12:0] mask;
    logic [15:0] step_thr;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] prev;
    logic prev_valid;
    logic [31:0] prdata;
    logic irq;
  } aif_state_type;

endpackage

// file: aif_status_flags_test.sv
// self-checking bench for the low interrupt status flags block
`timescale 1ns/1ps

module aif_status_flags_test;
  import aif_pkg::*;

  typedef struct packed {
    logic [12:0] ev;
    logic [15:0] adc;
    logic [12:0] st;
  } aif_row_type;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic adc_valid = 1'b0;
  logic [15:0] adc_result = 16'h0000;
  logic temp_ready = 1'b0;
  logic decim_ready = 1'b0;
  logic fourier_ready = 1'b0;
  logic mean_ready = 1'b0;
  logic variance_ready = 1'b0;
  logic seq_wr = 1'b0;
  logic [3:0] seq_wdata = 4'h0;
  logic [31:0] rdat;
  logic rerr;
  int num_errors = 0;
  int check_count = 0;
  // limits in use: upper 0x100, lower 0x10, step 0x20
  aif_row_type rows [16] = '{
    '{13'h0001, 16'h0050, 13'h0001}, '{13'h0002, 16'h0050, 13'h0002},
    '{13'h0004, 16'h0050, 13'h0004}, '{13'h0008, 16'h0050, 13'h0008},
    '{13'h0080, 16'h0050, 13'h0080}, '{13'h0100, 16'h0050, 13'h0100},
    '{13'h0200, 16'h0050, 13'h0200}, '{13'h0400, 16'h0050, 13'h0400},
    '{13'h0800, 16'h0050, 13'h0800}, '{13'h1000, 16'h0050, 13'h1000},
    '{13'h0001, 16'h0070, 13'h0001}, '{13'h0001, 16'h0100, 13'h0041},
    '{13'h0001, 16'h0101, 13'h0021}, '{13'h0001, 16'h0010, 13'h0041},
    '{13'h0001, 16'h000f, 13'h0011}, '{13'h1f8f, 16'h0030, 13'h1fcf}};

  aif_status_flags u_aif_status_flags (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .adc_valid(adc_valid),
    .adc_result(adc_result), .temp_ready(temp_ready), .decim_ready(decim_ready),
    .fourier_ready(fourier_ready), .mean_ready(mean_ready), .variance_ready(variance_ready),
    .seq_wr(seq_wr), .seq_wdata(seq_wdata));

  initial begin
    forever #25 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge, answer taken and
  // request released at that same edge; only the watchdog ends a stuck wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pulse(input logic [12:0] ev, input logic [15:0] v);
    @(posedge pclk);
    adc_valid <= ev[0];
    fourier_ready <= ev[1];
    decim_ready <= ev[2];
    temp_ready <= ev[3];
    mean_ready <= ev[7];
    variance_ready <= ev[8];
    seq_wr <= |ev[12:9];
    seq_wdata <= ev[12:9];
    adc_result <= v;
    @(posedge pclk);
    {adc_valid, fourier_ready, decim_ready, temp_ready} <= 4'h0;
    {mean_ready, variance_ready, seq_wr} <= 3'h0;
  endtask

  task automatic print_verdict();
    if (num_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // a hang would otherwise stall the run forever
  initial begin
    repeat (4000) @(posedge pclk);
    num_errors++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    check(rdat, 32'h0); // status after reset
    apb(1'b0, 8'h0c, 32'h0);
    check(rdat, 32'h0000_ffff);
    apb(1'b0, 8'h14, 32'h0);
    check(rdat, 32'h0);
    apb(1'b1, 8'h0c, 32'h20);
    apb(1'b1, 8'h10, 32'h100);
    apb(1'b1, 8'h14, 32'h10);
    foreach (rows[i]) begin
      pulse(rows[i].ev, rows[i].adc);
      apb(1'b0, 8'h00, 32'h0);
      check({rdat[31:7], 7'h0}, {19'h0, rows[i].st[12:7], 7'h0});
      check({29'h0, rdat[6:4]}, {29'h0, rows[i].st[6:4]});
      check({28'h0, rdat[3:0]}, {28'h0, rows[i].st[3:0]});
      check({31'h0, irq}, 32'h0);
      apb(1'b1, 8'h08, 32'h1fff);
      apb(1'b0, 8'h00, 32'h0);
      check(rdat, 32'h0);
    end
    // flags stay set until their own clear: 0x05 is below the lower limit and
    // more than the step threshold away from the previous result 0x30
    pulse(13'h0001, 16'h0005);
    repeat (5) @(posedge pclk);
    apb(1'b1, 8'h08, 32'h0001);
    apb(1'b0, 8'h00, 32'h0);
    check(rdat, 32'h0050); // sticky
    apb(1'b1, 8'h00, 32'h1fff);
    apb(1'b0, 8'h00, 32'h0);
    check(rdat, 32'h0050); // host write ignored
    apb(1'b1, 8'h08, 32'h0050);
    // mask and level interrupt
    apb(1'b1, 8'h04, 32'h0008);
    pulse(13'h0004, 16'h0);
    @(negedge pclk);
    check({31'h0, irq}, 32'h0); // masked out
    pulse(13'h0008, 16'h0);
    @(negedge pclk);
    check({31'h0, irq}, 32'h1); // unmasked event
    apb(1'b1, 8'h08, 32'h0008);
    @(negedge pclk);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, 8'h40, 32'hffff);
    check({31'h0, rerr}, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    check(rdat, 32'h0);
    // byte strobes: only byte 1 of the upper limit is written
    pstrb <= 4'h2;
    apb(1'b1, 8'h10, 32'h0000_aa55);
    pstrb <= 4'hf;
    apb(1'b0, 8'h10, 32'h0);
    check(rdat, 32'h0000_aa00);
    // reset in mid-run drops flags and mask
    pulse(13'h0008, 16'h0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check({31'h0, irq}, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    check(rdat, 32'h0); // reset clears
    apb(1'b0, 8'h04, 32'h0);
    check(rdat, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check(rdat, 32'h0000_ffff);
    print_verdict();
  end

endmodule
